//--- logic/afw_addr_check.v
// Address forming and implemented physical width checker
`timescale 1ns/1ps
// Overview of operation
// - Legacy linear addresses zero extend to 64
// - Pointer conversion maps four sections, regions 0-3
// - Region bits get no carry from add
// - Low 32 bits stay a usable pointer
// - Aliased stores visible to later aliased loads
// - Advanced-load table uses physical tags, stays coherent
// - Shared 63-bit physical space, 50 bits mapped
// - Translation enable bits zero select physical addressing
// - Between 32 and 63 contiguous physical bits
// - Top implemented bit is a fixed constant
// - Bits above top implemented set means unimplemented
// - Bad fetch address traps on last valid
// - Bad data address faults, never reaches memory
// - Platform time-out raises asynchronous machine check
// - Registers and breakpoints keep full widths
// - Insert with bad page number faults
// - Walker abandons insert with bad fields
// - Not-present translations skip page number checks
// - Physical bit 63 selects attribute, then dropped
module afw_addr_check (
    input wire clk,
    input wire srst,
    // Translation enables
    input wire instr_translate_enable,
    input wire data_translate_enable,
    input wire stack_translate_enable,
    // Reference request
    input wire req_valid,
    input wire [1:0] req_class,
    input wire req_is_store,
    input wire req_is_adv_load,
    input wire req_adv_chk,
    input wire [2:0] req_adv_idx,
    input wire req_last_valid_instr,
    input wire [63:0] req_addr,
    input wire [63:0] req_xlat_pa,
    // Pointer conversion request
    input wire pcv_valid,
    input wire pcv_shift_mode,
    input wire [1:0] pcv_shift,
    input wire [63:0] pcv_base,
    input wire [63:0] pcv_offset,
    // Translation inserts
    input wire ins_valid,
    input wire ins_from_walker,
    input wire ins_present,
    input wire ins_rsvd_set,
    input wire [49:0] ins_physical_page_number,
    // Platform time-out
    input wire plat_timeout,
    // Breakpoint register write
    input wire brk_wr,
    input wire [63:0] brk_addr_in,
    input wire [55:0] brk_mask_in,
    // Results
    output reg mem_valid_q,
    output reg [62:0] mem_pa_q,
    output reg phys_attribute_bit_q,
    output reg mem_is_store_q,
    output reg data_fault_q,
    output reg instr_trap_q,
    output reg machine_check_q,
    output reg pcv_valid_q,
    output reg [63:0] pcv_result_q,
    output reg ins_accept_q,
    output reg ins_fault_q,
    output reg walk_abort_q,
    output reg adv_hit_q,
    output reg [63:0] brk_addr_q,
    output reg [55:0] brk_mask_q,
    output reg [5:0] top_phys_bit_position_q
);
`include "afw_regs.vh"

// ****************************************
// Implemented width mask
// ****************************************

    wire [5:0] top_phys_bit_position;
    wire [62:0] unimpl_mask;
    wire [62:0] full_ones;

    // Fixed implementation constant, 62 means fully implemented
    assign top_phys_bit_position = `AFW_TOP_PHYS_BIT;
    assign full_ones = {63{1'b1}};
    // Ones from 62 down to top+1; empty mask when top is 62
    assign unimpl_mask = ~(full_ones >> (6'd62 - top_phys_bit_position));

// ****************************************
// Address forming per reference class
// ****************************************

    reg phys_mode;
    reg [63:0] eff_addr;
    reg [62:0] form_pa;
    reg form_attr;

    // Physical mode when the class's translate enable is clear
    always @* begin
        phys_mode = 1'b0;
        eff_addr = req_addr;
        case (req_class)
            `AFW_CLS_INSTR: begin
                phys_mode = !instr_translate_enable;
            end
            `AFW_CLS_DATA: begin
                phys_mode = !data_translate_enable;
            end
            `AFW_CLS_STACK: begin
                phys_mode = !stack_translate_enable;
            end
            `AFW_CLS_LEGACY: begin
                // Legacy references honour the data enable as well
                phys_mode = !data_translate_enable;
                eff_addr = {32'h00000000, req_addr[31:0]};
            end
            default: begin
                phys_mode = 1'b0;
            end
        endcase
    end

    // In physical mode bit 63 picks the attribute and is discarded from the address
    always @* begin
        if (phys_mode) begin
            form_attr = eff_addr[`AFW_ATTR_BIT];
            form_pa = eff_addr[62:0];
        end else begin
            // Translated: attribute fixed to AFW_ATTR_WBL, address taken from req_xlat_pa
            form_attr = `AFW_ATTR_WBL;
            form_pa = req_xlat_pa[62:0];
        end
    end

    wire pa_bad;
    wire is_instr;

    assign pa_bad = |(form_pa & unimpl_mask);
    assign is_instr = (req_class == `AFW_CLS_INSTR);

// ****************************************
// Reference outcome
// ****************************************

    // Bad addresses never reach memory; fetch traps wait for last valid
    always @(posedge clk) begin
        if (srst) begin
            mem_valid_q <= 1'b0;
            mem_pa_q <= 63'h0;
            phys_attribute_bit_q <= `AFW_ATTR_WBL;
            mem_is_store_q <= 1'b0;
            data_fault_q <= 1'b0;
            instr_trap_q <= 1'b0;
        end else begin
            mem_valid_q <= req_valid && !pa_bad;
            data_fault_q <= req_valid && pa_bad && !is_instr;
            instr_trap_q <= req_valid && pa_bad && is_instr && req_last_valid_instr;
            if (req_valid && !pa_bad) begin
                mem_pa_q <= form_pa;
                phys_attribute_bit_q <= form_attr;
                mem_is_store_q <= req_is_store;
            end
        end
    end

// ****************************************
// Machine check on platform time-out
// ****************************************

    // Sticky until reset; what happens next is up to the core
    always @(posedge clk) begin
        if (srst) begin
            machine_check_q <= 1'b0;
        end else if (plat_timeout) begin
            machine_check_q <= 1'b1;
        end
    end

// ****************************************
// Pointer conversion
// ****************************************

    reg [63:0] pcv_addend;
    wire [63:0] pcv_sum;

    // Shift variant scales the offset before the 32-bit add
    always @* begin
        if (pcv_shift_mode) begin
            // Three-bit count so a shift field of 3 scales by 16, not by 1
            pcv_addend = pcv_offset << ({1'b0, pcv_shift} + 3'd1);
        end else begin
            pcv_addend = pcv_offset;
        end
    end

    afw_ptr_conv u_conv (
        .base(pcv_base),
        .offset(pcv_addend),
        .result(pcv_sum)
    );

    // Low word stays the plain 32-bit pointer
    always @(posedge clk) begin
        if (srst) begin
            pcv_valid_q <= 1'b0;
            pcv_result_q <= `AFW_RST_ADDR;
        end else begin
            pcv_valid_q <= pcv_valid;
            if (pcv_valid) begin
                pcv_result_q <= pcv_sum;
            end
        end
    end

// ****************************************
// Translation insert checking
// ****************************************

    wire [62:0] ins_pa;
    wire ins_bad;

    assign ins_pa = {1'b0, ins_physical_page_number, 12'h000};
    // Not-present entries skip page number and reserved checks
    assign ins_bad = ins_present && ((|(ins_pa & unimpl_mask)) || ins_rsvd_set);

    always @(posedge clk) begin
        if (srst) begin
            ins_accept_q <= 1'b0;
            ins_fault_q <= 1'b0;
            walk_abort_q <= 1'b0;
        end else begin
            ins_accept_q <= ins_valid && !ins_bad;
            ins_fault_q <= ins_valid && !ins_from_walker && ins_bad;
            walk_abort_q <= ins_valid && ins_from_walker && ins_bad;
        end
    end

// ****************************************
// Alias coherence
// ****************************************

    wire alt_alloc;
    wire alt_snoop;
    wire alt_hit;

    // Physical tags make aliased stores kill stale advanced loads
    assign alt_alloc = req_valid && !pa_bad && req_is_adv_load && !req_is_store;
    assign alt_snoop = req_valid && !pa_bad && req_is_store;

    afw_alias_table u_alt (
        .clk(clk),
        .srst(srst),
        .alloc(alt_alloc),
        .alloc_idx(req_adv_idx),
        .alloc_pa(form_pa),
        .snoop(alt_snoop),
        .snoop_pa(form_pa),
        .chk(req_adv_chk),
        .chk_idx(req_adv_idx),
        .chk_hit_q(alt_hit)
    );

    always @(posedge clk) begin
        if (srst) begin
            adv_hit_q <= 1'b0;
        end else begin
            adv_hit_q <= alt_hit;
        end
    end

// ****************************************
// Breakpoint registers and width report
// ****************************************

    // Full widths kept whatever the implemented address width
    always @(posedge clk) begin
        if (srst) begin
            brk_addr_q <= `AFW_RST_ADDR;
            brk_mask_q <= 56'h0;
            top_phys_bit_position_q <= 6'h00;
        end else begin
            top_phys_bit_position_q <= top_phys_bit_position;
            if (brk_wr) begin
                brk_addr_q <= brk_addr_in;
                brk_mask_q <= brk_mask_in;
            end
        end
    end
endmodule

//--- pkg/afw_regs.vh
// Constants for the address forming and implemented-width check block
`ifndef AFW_REGS_VH
`define AFW_REGS_VH

// Address widths
`define AFW_ADDR_W 64
`define AFW_LIN_W 32
`define AFW_PA_W 63
`define AFW_MAP_PA_W 50
`define AFW_BRK_MASK_W 56

// Field positions
`define AFW_ATTR_BIT 63
`define AFW_PA_MSB_FULL 62
`define AFW_PCV_HI 62
`define AFW_PCV_LO 61
`define AFW_PCV_SRC_HI 31
`define AFW_PCV_SRC_LO 30
`define AFW_PPN_LSB 12

// Implemented physical width; must lie between 31 and 62
`define AFW_TOP_PHYS_BIT 6'd49

// Attribute codes driven on the attribute output
`define AFW_ATTR_WBL 1'b0
`define AFW_ATTR_UC 1'b1

// Reference classes
`define AFW_CLS_INSTR 2'h0
`define AFW_CLS_DATA 2'h1
`define AFW_CLS_STACK 2'h2
`define AFW_CLS_LEGACY 2'h3

// Reset values
`define AFW_RST_ADDR 64'h0000000000000000
`define AFW_RST_ALT_TAG 63'h0

// Number of tracked advanced loads
`define AFW_ALT_ENTRIES 8
`define AFW_ALT_IDX_W 3

`endif

//--- logic/afw_ptr_conv.v
// Pointer conversion adder for 32-bit swizzled addressing
`timescale 1ns/1ps
module afw_ptr_conv (
    input wire [63:0] base,
    input wire [63:0] offset,
    output wire [63:0] result
);
`include "afw_regs.vh"

    wire [31:0] sum;

    // Only the low word adds; no carry ever reaches the region bits
    assign sum = base[31:0] + offset[31:0];
    // Region bits copied from source, rest of the upper word zeroed
    assign result = {1'b0, base[`AFW_PCV_SRC_HI:`AFW_PCV_SRC_LO], 29'h00000000, sum};
endmodule

//--- logic/afw_alias_table.v
// Physical-tag table of advanced loads, coherent with physical stores
`timescale 1ns/1ps
module afw_alias_table (
    input wire clk,
    input wire srst,
    input wire alloc,
    input wire [2:0] alloc_idx,
    input wire [62:0] alloc_pa,
    input wire snoop,
    input wire [62:0] snoop_pa,
    input wire chk,
    input wire [2:0] chk_idx,
    output reg chk_hit_q
);
`include "afw_regs.vh"

    reg [62:0] tag_q [0:`AFW_ALT_ENTRIES-1];
    reg [`AFW_ALT_ENTRIES-1:0] vld_q;
    integer i;

    // Tags are physical so any virtual alias of a store kills the entry
    always @(posedge clk) begin
        if (srst) begin
            vld_q <= {`AFW_ALT_ENTRIES{1'b0}};
            chk_hit_q <= 1'b0;
            for (i = 0; i < `AFW_ALT_ENTRIES; i = i + 1) begin
                tag_q[i] <= `AFW_RST_ALT_TAG;
            end
        end else begin
            for (i = 0; i < `AFW_ALT_ENTRIES; i = i + 1) begin
                if (snoop && vld_q[i] && tag_q[i] == snoop_pa) begin
                    vld_q[i] <= 1'b0;
                end
            end
            // Allocation wins over a same-cycle snoop of its own entry
            if (alloc) begin
                tag_q[alloc_idx] <= alloc_pa;
                vld_q[alloc_idx] <= 1'b1;
            end
            chk_hit_q <= chk && vld_q[chk_idx] &&
                !(snoop && tag_q[chk_idx] == snoop_pa);
        end
    end
endmodule

//--- verif/afw_addr_check_properties.sv
// Concurrent checks on the address forming and width check block ports
`timescale 1ns/1ps
module afw_addr_check_properties (
    input wire clk,
    input wire srst,
    input wire instr_translate_enable,
    input wire data_translate_enable,
    input wire req_valid,
    input wire [1:0] req_class,
    input wire req_last_valid_instr,
    input wire [63:0] req_addr,
    input wire pcv_valid,
    input wire pcv_shift_mode,
    input wire [63:0] pcv_base,
    input wire [63:0] pcv_offset,
    input wire ins_valid,
    input wire ins_from_walker,
    input wire ins_present,
    input wire [49:0] ins_physical_page_number,
    input wire plat_timeout,
    input wire brk_wr,
    input wire [63:0] brk_addr_in,
    input wire [55:0] brk_mask_in,
    input wire mem_valid_q,
    input wire [62:0] mem_pa_q,
    input wire phys_attribute_bit_q,
    input wire data_fault_q,
    input wire instr_trap_q,
    input wire machine_check_q,
    input wire pcv_valid_q,
    input wire [63:0] pcv_result_q,
    input wire ins_accept_q,
    input wire walk_abort_q,
    input wire ins_fault_q,
    input wire adv_hit_q,
    input wire [63:0] brk_addr_q,
    input wire [55:0] brk_mask_q,
    input wire [5:0] top_phys_bit_position_q
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // Physical references by class; bit 49 is the top implemented bit
    wire dph = req_valid && req_class == 2'h1 && !data_translate_enable;
    wire iph = req_valid && req_class == 2'h0 && !instr_translate_enable;
    wire lph = req_valid && req_class == 2'h3 && !data_translate_enable;
    wire bad = |req_addr[62:50];
    wire ibad = ins_valid && ins_present && |ins_physical_page_number[49:38];

    AST_DATA_OK: assert property (dph && !bad |=> mem_valid_q &&
        mem_pa_q == $past(req_addr[62:0]) && phys_attribute_bit_q == $past(req_addr[63]))
        else $error("data ref misformed");
    AST_DATA_BAD: assert property (dph && bad |=> data_fault_q && !mem_valid_q)
        else $error("bad data ref not faulted");
    AST_FETCH_TRAP: assert property (iph && bad && req_last_valid_instr |=> instr_trap_q)
        else $error("bad fetch not trapped");
    AST_LEGACY: assert property (lph |=> mem_valid_q && mem_pa_q[62:32] == 31'h0)
        else $error("legacy ref not zero extended");
    AST_PCV: assert property (pcv_valid && !pcv_shift_mode |=> pcv_valid_q &&
        pcv_result_q == {1'b0, $past(pcv_base[31:30]), 29'h0,
        $past(pcv_base[31:0] + pcv_offset[31:0])})
        else $error("pointer conversion wrong");
    AST_SW_INSERT: assert property (ibad && !ins_from_walker
        |=> ins_fault_q && !ins_accept_q)
        else $error("bad insert accepted");
    AST_WALK_ABORT: assert property (ibad && ins_from_walker
        |=> walk_abort_q && !ins_accept_q)
        else $error("walker insert not abandoned");
    AST_NOT_PRESENT: assert property (ins_valid && !ins_present |=> ins_accept_q)
        else $error("absent translation refused");
    AST_MCHK: assert property (plat_timeout |=> machine_check_q [*4])
        else $error("machine check missing");
    AST_BRK: assert property (brk_wr |=> brk_addr_q == $past(brk_addr_in) &&
        brk_mask_q == $past(brk_mask_in))
        else $error("breakpoint width lost");
    AST_TOP: assert property (!$past(srst) && !$past(srst, 2)
        |-> top_phys_bit_position_q == 6'h31)
        else $error("top bit position wrong");

    // Main scenarios reached
    cover property (data_fault_q);
    cover property (instr_trap_q);
    cover property (walk_abort_q);
    cover property (adv_hit_q);
endmodule

bind afw_addr_check afw_addr_check_properties i_props (.*);

//--- verif/afw_mem_model.sv
// Memory system model that times out on an unpopulated range
`timescale 1ns/1ps
module afw_mem_model (
    input wire clk,
    input wire srst,
    input wire mem_valid_q,
    input wire [62:0] mem_pa_q,
    output reg plat_timeout
);
    // ****************************************
    // Platform response
    // ****************************************
    initial plat_timeout = 1'b0;
    // Range with bits 49:48 both set is unpopulated; answers late on purpose
    always @(negedge clk) plat_timeout <= !srst && mem_valid_q && mem_pa_q[49:48] == 2'h3;
endmodule

//--- verif/afw_addr_check_tb.sv
// Self-checking bench for the address forming and width check block
`timescale 1ns/1ps
module afw_addr_check_tb;
    // ****************************************
    // Stimulus and checking
    // ****************************************
    reg clk, srst, ite, dte, ste, rv, st, adl, ach, lvi, pv, pm, iv, iw, ip, ir, bw;
    reg [1:0] rc, ps;
    reg [2:0] ri;
    reg [63:0] ra, rx, pb, po, ba;
    reg [49:0] pn;
    reg [55:0] bm;
    reg [31:0] rn;
    wire mv, ms, df, it, mc, pq, ia, ifl, wa, ah, pt, at;
    wire [62:0] mp;
    wire [63:0] pr, bq;
    wire [55:0] bmq;
    wire [5:0] tp;
    integer bad_count, num_checks, cyc, k;

    afw_addr_check i_dut (.clk(clk), .srst(srst), .instr_translate_enable(ite),
        .data_translate_enable(dte), .stack_translate_enable(ste), .req_valid(rv),
        .req_class(rc), .req_is_store(st), .req_is_adv_load(adl), .req_adv_chk(ach),
        .req_adv_idx(ri), .req_last_valid_instr(lvi), .req_addr(ra), .req_xlat_pa(rx),
        .pcv_valid(pv), .pcv_shift_mode(pm), .pcv_shift(ps), .pcv_base(pb), .pcv_offset(po),
        .ins_valid(iv), .ins_from_walker(iw), .ins_present(ip), .ins_rsvd_set(ir),
        .ins_physical_page_number(pn), .plat_timeout(pt), .brk_wr(bw), .brk_addr_in(ba),
        .brk_mask_in(bm), .mem_valid_q(mv), .mem_pa_q(mp), .phys_attribute_bit_q(at),
        .mem_is_store_q(ms), .data_fault_q(df), .instr_trap_q(it), .machine_check_q(mc),
        .pcv_valid_q(pq), .pcv_result_q(pr), .ins_accept_q(ia), .ins_fault_q(ifl),
        .walk_abort_q(wa), .adv_hit_q(ah), .brk_addr_q(bq), .brk_mask_q(bmq),
        .top_phys_bit_position_q(tp));
    afw_mem_model i_mem (.clk(clk), .srst(srst), .mem_valid_q(mv), .mem_pa_q(mp),
        .plat_timeout(pt));

    // Free running 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task cmp(input [64:0] g, input [64:0] e);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                bad_count = bad_count + 1;
                $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask

    task final_report;
        begin
            $display("checks=%0d mismatches=%0d", num_checks, bad_count);
            if (bad_count == 0 && num_checks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    // Reset held four cycles; top bit position settles two edges later
    task rst;
        begin
            srst = 1'b1;
            repeat (4) @(negedge clk);
            srst = 1'b0;
            repeat (2) @(negedge clk);
        end
    endtask

    // One reference; expectation from class, enables and implemented width
    task req(input [1:0] c, input [63:0] a, input [63:0] x, input [3:0] f, input [2:0] i);
        reg [63:0] v;
        reg g;
        begin
            v = (c == 2'h3) ? {32'h0, a[31:0]} : a;
            if (c == 2'h0 ? ite : c == 2'h2 ? ste : dte)
                v = {1'b0, x[62:0]};
            g = !(|v[62:50]);
            @(negedge clk);
            {rc, ra, rx, lvi, st, adl, ach, ri, rv} = {c, a, x, f, i, 1'b1};
            @(negedge clk);
            rv = 1'b0;
            ach = 1'b0;
            cmp({mv, df, it, ms && mv}, g ? {3'h4, f[2]} : c ? 4'h4 : {2'h0, f[3], 1'b0});
            if (g)
                cmp({at, mp}, v);
        end
    endtask

    task ins(input w, input p, input r, input [49:0] n);
        begin
            @(negedge clk);
            {iw, ip, ir, pn, iv} = {w, p, r, n, 1'b1};
            @(negedge clk);
            iv = 1'b0;
            cmp({ia, ifl, wa}, !p || !(r || |n[49:38]) ? 3'h4 : w ? 3'h1 : 3'h2);
        end
    endtask

    task pcv(input m, input [1:0] s, input [63:0] b, input [63:0] o);
        reg [31:0] e;
        begin
            e = b[31:0] + (m ? o[31:0] << ({1'b0, s} + 3'd1) : o[31:0]);
            @(negedge clk);
            {pm, ps, pb, po, pv} = {m, s, b, o, 1'b1};
            @(negedge clk);
            pv = 1'b0;
            cmp({pq, pr}, {2'h2, b[31:30], 29'h0, e});
        end
    endtask

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            bad_count = bad_count + 1;
            final_report;
        end
    end

    initial begin
        {srst, ite, dte, ste, rv, st, adl, ach, lvi, pv, pm, iv, iw, ip, ir, bw} = 16'hFFFF;
        {rc, ps, ri, ra, rx, pb, po, ba, pn, bm} = 0;
        {ite, dte, ste, rv, st, adl, ach, lvi, pv, pm, iv, iw, ip, ir, bw} = 15'h0;
        {bad_count, num_checks, cyc} = 0;
        rn = $urandom(32'h402A94F6);
        rst;
        cmp(tp, 6'h31);
        // Corner references at the implemented edge, in physical mode
        req(2'h1, 64'h8000_0000_0000_0100, 0, 4'h0, 3'h0);
        req(2'h1, 64'h0002_FFFF_FFFF_FFFF, 0, 4'h4, 3'h0);
        req(2'h1, 64'h0004_0000_0000_0000, 0, 4'h0, 3'h0);
        req(2'h2, 64'h4000_0000_0000_0000, 0, 4'h0, 3'h0);
        req(2'h0, 64'h0004_0000_0000_0000, 0, 4'h8, 3'h0);
        req(2'h0, 64'h0004_0000_0000_0000, 0, 4'h0, 3'h0);
        req(2'h3, 64'hFFFF_FFFF_8000_0000, 0, 4'h0, 3'h0);
        // Advanced load killed by a store through a translated alias
        req(2'h1, 64'h1000, 0, 4'h2, 3'h5);
        req(2'h1, 64'h1000, 0, 4'h1, 3'h5);
        @(negedge clk);
        cmp(ah, 1'b1);
        dte = 1'b1;
        req(2'h1, 64'h0000_2000_0010_1000, 64'h1000, 4'h4, 3'h0);
        dte = 1'b0;
        req(2'h1, 64'h1000, 0, 4'h1, 3'h5);
        @(negedge clk);
        cmp(ah, 1'b0);
        // Random traffic across every class, enable and converter mode
        for (k = 0; k < 40; k = k + 1) begin
            rn = $urandom;
            {ite, dte, ste} = rn[8:6];
            req(rn[1:0], {$urandom, $urandom} & (rn[9] ? ~64'h0 : 64'h8002_FFFF_FFFF_FFFF),
                {$urandom, $urandom} & 64'h0002_FFFF_FFFF_FFFF, rn[5:2], rn[12:10]);
            pcv(rn[13], rn[15:14], {$urandom, $urandom}, {$urandom, $urandom});
            ins(rn[16], rn[17], rn[18], {$urandom, $urandom} & (rn[19] ? ~50'h0 : 50'h3F_FFFF_FFFF));
            @(negedge clk);
            {ba, bm, bw} = {$urandom, $urandom, $urandom, $urandom, 1'b1};
            @(negedge clk);
            bw = 1'b0;
            cmp({bq, bmq}, {ba, bm});
        end
        {ite, dte, ste} = 3'h0;
        pcv(1'b0, 2'h0, 64'hC000_0000, 64'h10);
        pcv(1'b0, 2'h0, 64'hFFFF_FFFF, 64'h1);
        ins(1'b0, 1'b1, 1'b0, 50'h20_0000_0000);
        ins(1'b1, 1'b1, 1'b0, 50'h40_0000_0000);
        ins(1'b0, 1'b1, 1'b1, 50'h0);
        ins(1'b0, 1'b0, 1'b1, ~50'h0);
        // Second reset, then a reference into the unpopulated range
        rst;
        cmp(mc, 1'b0);
        req(2'h1, 64'h0003_0000_0000_0000, 0, 4'h0, 3'h0);
        repeat (2) @(negedge clk);
        cmp(mc, 1'b1);
        final_report;
    end
endmodule
